/* bench/xnm_mem_model.sv */
// Behavioural memory answering the sequencer's request/acknowledge port
module xnm_mem_model (
  input wire logic core_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic [31:0] mem_rdata = 32'h0,
  output logic mem_ack = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Byte store
  // ----
  logic [7:0] mem [int unsigned];
  logic [3:0] wait_n = 4'h0;
  // Unwritten bytes read as zero so the bench can preload only what it uses
  function automatic logic [31:0] get(input logic [31:0] a);
    logic [31:0] w;
    w = 32'h0;
    for (int k = 0; k < 4; k++) begin
      if (mem.exists(a + k))
        w[8 * k +: 8] = mem[a + k];
    end
    return w;
  endfunction
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    for (int k = 0; k < 4; k++)
      mem[a + k] = d[8 * k +: 8];
  endtask
  // Answer after lat idle cycles; read data runs free while nothing is answered
  always @(posedge core_clk) begin
    if (mem_req && !mem_ack && wait_n >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= get(mem_addr);
      wait_n <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_n <= (mem_req && !mem_ack) ? wait_n + 4'h1 : 4'h0;
    end
    if (mem_req && mem_ack && mem_we) begin
      for (int k = 0; k < (1 << mem_size); k++)
        mem[mem_addr + k] = mem_wdata[8 * k +: 8];
    end
  end
endmodule

/* bench/xnm_seq_properties.sv */
// Port checker for the normal-mode transfer sequencer
`include "xnm_consts.svh"
module xnm_seq_properties
  import xnm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic cpu_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Activation tracking
  // ----
  logic [3:0] acc_n;
  logic [31:0] info_base;
  logic [15:0] cnt_rd;
  logic every;
  wire logic [31:0] ofs = {26'h0, acc_n, 2'h0};
  // Accesses done so far; req stays up until the one idle closing cycle
  always_ff @(posedge core_clk) begin
    if (srst || !mem_req) begin
      acc_n <= 4'h0;
    end else if (mem_ack) begin
      acc_n <= acc_n + 4'h1;
    end
  end
  // Words fetched early that later accesses are judged against
  always_ff @(posedge core_clk) begin
    if (srst) begin
      info_base <= 32'h0;
      cnt_rd <= 16'h0;
      every <= 1'b0;
    end else if (mem_req && mem_ack) begin
      if (acc_n == 4'h0)
        info_base <= mem_rdata;
      if (acc_n == 4'h1)
        every <= mem_rdata[`XNM_MODE_EVERY_BIT];
      if (acc_n == 4'h4)
        cnt_rd <= mem_rdata[15:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ----
  // Properties
  // ----
  bus_okay_a:
    assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  req_hold_a:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before its answer");
  vec_first_a:
    assert property (mem_req && acc_n == 4'h0 |-> !mem_we && mem_size == `XNM_SZ_WORD)
    else $error("first access is not a word read");
  info_rd_a:
    assert property (mem_req && acc_n inside {[1:4]} |->
                     !mem_we && mem_addr == info_base + ofs - 32'h4)
    else $error("information read at wrong place");
  data_mv_a:
    assert property (mem_req && mem_ack && acc_n == 4'h5 |-> !mem_we ##1 mem_req && mem_we)
    else $error("data read not followed by data write");
  wb_addr_a:
    assert property (mem_req && acc_n inside {[7:9]} |->
                     mem_we && mem_addr == info_base + ofs - 32'h18)
    else $error("write-back at wrong place");
  cnt_dec_a:
    assert property (mem_req && acc_n == 4'h9 |-> mem_wdata[15:0] == cnt_rd - 16'h1)
    else $error("count not decremented by one");
  fin_a:
    assert property (mem_req && mem_ack && acc_n == 4'h9 |=> !mem_req)
    else $error("access beyond the write-back");
  irq_due_a:
    assert property ($fell(mem_req) && (cnt_rd == 16'h1 || every) |=> cpu_irq)
    else $error("interrupt missing after transfer");
  irq_quiet_a:
    assert property ($fell(mem_req) && cnt_rd != 16'h1 && !every |=> !$rose(cpu_irq))
    else $error("interrupt after non-final transfer");
  cover property ($fell(mem_req) && cnt_rd == 16'h1);
  cover property ($fell(mem_req) && every);
  cover property (mem_req && !mem_ack ##1 mem_req && !mem_ack);
endmodule
bind xnm_seq xnm_seq_properties u_props (
  .core_clk, .srst, .hreadyout, .hresp, .mem_req, .mem_we, .mem_addr,
  .mem_size, .mem_wdata, .mem_rdata, .mem_ack, .cpu_irq
);

/* bench/xnm_seq_tb_top.sv */
// Bench driving both sequencer variants over one shared register bus
`include "xnm_consts.svh"
module xnm_seq_tb_top
  import xnm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] lat [2] = '{4'h0, 4'h0};
  logic [31:0] rdata [2];
  wire logic [31:0] hrdata [2], mem_addr [2], mem_wdata [2], mem_rdata [2];
  wire logic [1:0] mem_size [2];
  wire logic hready [2], mem_req [2], mem_we [2], mem_ack [2], cpu_irq [2];
  int fail_count = 0;
  int cmp_count = 0;
  logic [31:0] modes [3] = '{32'h29, 32'h44, 32'h12};
  logic [15:0] cnts [3] = '{16'h3, 16'h0, 16'h3};
  // 10 MHz core clock
  always #50 core_clk = ~core_clk;
  // Instance 0 is the flag variant, 1 the enable-bit one; each has its own memory
  for (genvar i = 0; i < 2; i++) begin : g_v
    xnm_seq #(.FLAG_VARIANT(i == 0), .SRC_VECTOR(7'h05)) DUT (
      .core_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hready[0]),
      .hwdata, .hreadyout(hready[i]), .hresp(), .hrdata(hrdata[i]), .mem_req(mem_req[i]),
      .mem_we(mem_we[i]), .mem_addr(mem_addr[i]), .mem_size(mem_size[i]),
      .mem_wdata(mem_wdata[i]), .mem_rdata(mem_rdata[i]), .mem_ack(mem_ack[i]),
      .cpu_irq(cpu_irq[i]));
    xnm_mem_model u_mem (
      .core_clk, .mem_req(mem_req[i]), .mem_we(mem_we[i]), .mem_addr(mem_addr[i]),
      .mem_size(mem_size[i]), .mem_wdata(mem_wdata[i]), .lat(lat[i]),
      .mem_rdata(mem_rdata[i]), .mem_ack(mem_ack[i]));
  end
  // ----
  // Tasks
  // ----
  // One single word transfer; both slaves answer, their read data land in rdata
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hready[0] !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hready[0] !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] mget(input int i, input logic [31:0] a);
    return (i == 0) ? g_v[0].u_mem.get(a) : g_v[1].u_mem.get(a);
  endfunction
  function automatic logic [31:0] nxt(logic [31:0] b, logic [1:0] m, logic [31:0] s);
    return (m == `XNM_AM_INC) ? b + s : (m == `XNM_AM_DEC) ? b - s : b;
  endfunction
  // Vector 5 at base 0x100 points at information at 0x200 in both memories
  task automatic load(input logic [31:0] mode, input logic [15:0] cnt);
    logic [31:0] w [7];
    w = '{32'h200, mode, 32'h1000, 32'h2000, {16'h0, cnt}, 32'hA5C3_9E71, 32'h0};
    for (int k = 0; k < 7; k++) begin
      g_v[0].u_mem.put(k == 0 ? 32'h114 : k > 4 ? 32'h1000 * (k - 4) : 32'h1FC + 4 * k, w[k]);
      g_v[1].u_mem.put(k == 0 ? 32'h114 : k > 4 ? 32'h1000 * (k - 4) : 32'h1FC + 4 * k, w[k]);
    end
  endtask
  // Software starts both variants, then polls until neither is busy
  task automatic fire();
    bus(1'b1, `XNM_OFS_CTRL, 32'h1);
    bus(1'b1, `XNM_OFS_SWREQ, 32'h1);
    bus(1'b0, `XNM_OFS_STAT, 32'h0);
    chk(rdata[0] & 32'h1, 32'h1);
    bus(1'b1, `XNM_OFS_VECACT, 32'h85);
    repeat (2) @(posedge core_clk);
    repeat (300) begin
      bus(1'b0, `XNM_OFS_STAT, 32'h0);
      if (rdata[0][1] === 1'b0 && rdata[1][1] === 1'b0)
        break;
    end
    // A poll limit that runs out must count as a mismatch
    chk({30'h0, rdata[1][1], rdata[0][1]}, 32'h0);
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A run needs some 300 cycles; twenty thousand leaves ample margin
  initial begin
    #2_000_000;
    fail_count++;
    close_out();
  end
  // ----
  // Tests
  // ----
  initial begin
    logic [31:0] s;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    for (logic [7:0] a = 8'h00; a < 8'h20; a += 8'h04) begin
      bus(1'b0, a, 32'h0);
      chk(rdata[0], 32'h0);
      chk(rdata[1], 32'h0);
    end
    $display("test reset_and_map done");
    bus(1'b1, `XNM_OFS_VBASE, 32'h100);
    load(32'h05, 16'h2);
    fire();
    chk(rdata[0], 32'h0001_0000);
    chk(rdata[1], 32'h0001_0000);
    bus(1'b0, `XNM_OFS_CTRL, 32'h0);
    chk(rdata[0], 32'h1);
    bus(1'b0, `XNM_OFS_VECACT, 32'h0);
    chk(rdata[1], 32'h05);
    for (int i = 0; i < 2; i++) begin
      chk({31'h0, cpu_irq[i]}, 32'h0);
      chk(mget(i, 32'h204), 32'h1001);
      chk(mget(i, 32'h20C), 32'h1);
      chk(mget(i, 32'h2000), 32'h71);
    end
    fire();
    chk(rdata[0], 32'h5);
    chk(rdata[1], 32'h4);
    bus(1'b0, `XNM_OFS_CTRL, 32'h0);
    chk(rdata[0], 32'h0);
    bus(1'b0, `XNM_OFS_VECACT, 32'h0);
    chk(rdata[1], 32'h85);
    for (int i = 0; i < 2; i++) begin
      chk({31'h0, cpu_irq[i]}, 32'h1);
      chk(mget(i, 32'h2000), 32'h9E71);
      chk(mget(i, 32'h20C), 32'h0);
    end
    bus(1'b1, `XNM_OFS_VECACT, 32'h05);
    bus(1'b0, `XNM_OFS_STAT, 32'h0);
    chk(rdata[0], 32'h5);
    chk(rdata[1], 32'h0);
    bus(1'b1, `XNM_OFS_IACK, 32'h1);
    bus(1'b0, `XNM_OFS_STAT, 32'h0);
    chk(rdata[0], 32'h0);
    chk(rdata[1], 32'h0);
    $display("test count_two done");
    // Slow memory from here on, with a different wait on each side
    lat[0] <= 4'h2;
    lat[1] <= 4'h3;
    for (int k = 0; k < 3; k++) begin
      load(modes[k], cnts[k]);
      fire();
      for (int i = 0; i < 2; i++) begin
        s = (modes[k][5:4] == `XNM_SZ_BYTE) ? 1 : (modes[k][5:4] == `XNM_SZ_HALF || i) ? 2 : 4;
        chk(mget(i, 32'h204), nxt(32'h1000, modes[k][1:0], s));
        chk(mget(i, 32'h208), nxt(32'h2000, modes[k][3:2], s));
        chk(mget(i, 32'h20C), {16'h0, cnts[k] - 16'h1});
        chk(mget(i, 32'h2000), 32'hA5C3_9E71 & (32'hFFFF_FFFF >> (32 - 8 * s)));
        chk({31'h0, cpu_irq[i]}, {31'h0, modes[k][6]});
      end
      bus(1'b1, `XNM_OFS_IACK, 32'h1);
    end
    $display("test modes_and_sizes done");
    close_out();
  end
endmodule

/* hw/xnm_ahb_slv.sv */
// AHB-Lite slave front end that turns bus transfers into register strobes
module xnm_ahb_slv
  import xnm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata
);
  logic ap_valid;
  logic ap_write;

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  // Only whole-word NONSEQ/SEQ transfers are taken; narrower ones are ignored
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      reg_addr <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1] && (hsize == 3'h2);
      ap_write <= hwrite;
      reg_addr <= haddr[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Data phase: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign reg_wr = ap_valid && ap_write;
  assign reg_wdata = hwdata;
  assign hrdata = (ap_valid && !ap_write) ? reg_rdata : 32'h0000_0000;
endmodule

/* hw/xnm_consts.svh */
// Register offsets, field positions, reset values and encodings of the normal-mode sequencer
`ifndef XNM_CONSTS_SVH
`define XNM_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets (low address byte)
// ----------------------------------------------------------------
`define XNM_OFS_CTRL 8'h00
`define XNM_OFS_SWREQ 8'h04
`define XNM_OFS_VECACT 8'h08
`define XNM_OFS_VBASE 8'h0C
`define XNM_OFS_STAT 8'h10
`define XNM_OFS_IACK 8'h14

// ----------------------------------------------------------------
// Register fields
// ----------------------------------------------------------------
`define XNM_CTRL_XEN_BIT 0
`define XNM_SWREQ_BIT 0
`define XNM_VECACT_SAE_BIT 7
`define XNM_VECACT_VEC_HI 6
`define XNM_IACK_BIT 0
`define XNM_STAT_PEND_BIT 0
`define XNM_STAT_BUSY_BIT 1
`define XNM_STAT_IRQ_BIT 2
`define XNM_STAT_CNT_LO 16
`define XNM_VBASE_RST 32'h0000_0000

// ----------------------------------------------------------------
// Transfer information in memory: word 0 mode, 1 source, 2 dest, 3 count
// ----------------------------------------------------------------
`define XNM_INFO_LAST_IDX 2'h3
`define XNM_INFO_FIRST_WB 2'h1
`define XNM_WORD_STEP 32'h0000_0004
`define XNM_MODE_SRC_LO 0
`define XNM_MODE_DST_LO 2
`define XNM_MODE_SIZE_LO 4
`define XNM_MODE_EVERY_BIT 6
`define XNM_AM_FIXED 2'h0
`define XNM_AM_INC 2'h1
`define XNM_AM_DEC 2'h2
`define XNM_SZ_BYTE 2'h0
`define XNM_SZ_HALF 2'h1
`define XNM_SZ_WORD 2'h2
`define XNM_STEP_1 32'h0000_0001
`define XNM_STEP_2 32'h0000_0002
`define XNM_STEP_4 32'h0000_0004
`define XNM_CNT_ONE 16'h0001
`define XNM_CNT_ZERO 16'h0000
`define XNM_CNT_DEC 16'h0001

`endif

/* hw/xnm_pkg.sv */
// Types shared by the normal-mode sequencer files
package xnm_pkg;
  typedef enum logic [2:0] {
    XNM_IDLE,
    XNM_VEC_RD,
    XNM_INFO_RD,
    XNM_DAT_RD,
    XNM_DAT_WR,
    XNM_WB,
    XNM_FIN
  } xnm_state_e;
endpackage

/* hw/xnm_seq.sv */
// Normal-mode transfer sequencer with software activation and register access
// How it works
// RQ1 - Build-time choice between flag and enable variants
// RQ2 - Software sets source transfer enable first
// RQ3 - Soft request write sets pending flag, activates
// RQ4 - Activation first reads the selected vector entry
// RQ5 - Then reads transfer information, then moves data
// RQ6 - Count not one: pending flag cleared at start
// RQ7 - Each completed transfer decrements counter A
// RQ8 - Flag variant writes information back after transfer
// RQ9 - Non-final flag transfer: enable stays, no interrupt
// RQ10 - Software rewrites soft request per activation
// RQ11 - Final transfer start leaves pending flag set
// RQ12 - Final completion clears enable, interrupts the CPU
// RQ13 - CPU acceptance clears the pending flag
// RQ14 - Writing activation enable one requests a transfer
// RQ15 - Enable variant writes back before completion check
// RQ16 - Count not zero: clear enable, no interrupt
// RQ17 - Software rewrites activation enable per activation
// RQ18 - Final completion keeps enable, raises end interrupt
// RQ19 - End handler clears the activation enable
// RQ20 - Addresses step by size, increment/decrement/fixed
// RQ21 - Count 1 to 65536, zero means 65536
// RQ22 - Optional interrupt after every single transfer
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
module xnm_seq
  import xnm_pkg::*;
#(
  parameter bit FLAG_VARIANT = 1'b1,
  parameter logic [6:0] SRC_VECTOR = 7'h00
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic cpu_irq
);
`include "xnm_consts.svh"

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  xnm_state_e state;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [1:0] idx;
  logic [31:0] info_base;
  logic [31:0] src;
  logic [31:0] dst;
  logic [15:0] count_a;
  logic [1:0] src_mode;
  logic [1:0] dst_mode;
  logic [1:0] xsize;
  logic every;
  logic [31:0] vbase;
  logic [6:0] vec_num;
  logic pending_request_flag;
  logic xfer_enable_per_source;
  logic soft_activation_enable;
  logic act_req;
  logic activate;
  logic xfer_start;
  logic start_final;
  logic xfer_done;
  logic done_final;
  logic wr_ctrl;
  logic wr_swreq;
  logic wr_vecact;
  logic wr_iack;
  logic [31:0] next_src;
  logic [31:0] next_dst;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Enable variant has no longword step, so a word size degrades to two
  function automatic logic [1:0] eff_size(input logic [1:0] sz);
    if (!FLAG_VARIANT && sz == `XNM_SZ_WORD) begin // RQ1
      return `XNM_SZ_HALF;
    end
    return sz;
  endfunction

  // Address update after one datum
  function automatic logic [31:0] adv(input logic [31:0] a, input logic [1:0] mode,
                                      input logic [1:0] sz);
    logic [31:0] st;
    st = (sz == `XNM_SZ_BYTE) ? `XNM_STEP_1 :
         (sz == `XNM_SZ_HALF) ? `XNM_STEP_2 : `XNM_STEP_4;
    case (mode) // RQ20
      `XNM_AM_INC: return a + st;
      `XNM_AM_DEC: return a - st;
      default: return a;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  xnm_ahb_slv u_slv (
    .core_clk(core_clk),
    .srst(srst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );

  // Address decode of write strobes
  always_comb begin
    wr_ctrl = 1'b0;
    wr_swreq = 1'b0;
    wr_vecact = 1'b0;
    wr_iack = 1'b0;
    if (reg_wr && reg_addr == `XNM_OFS_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (reg_wr && reg_addr == `XNM_OFS_SWREQ) begin
      wr_swreq = 1'b1;
    end else if (reg_wr && reg_addr == `XNM_OFS_VECACT) begin
      wr_vecact = 1'b1;
    end else if (reg_wr && reg_addr == `XNM_OFS_IACK) begin
      wr_iack = reg_wdata[`XNM_IACK_BIT];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (reg_addr == `XNM_OFS_CTRL) begin
      reg_rdata[`XNM_CTRL_XEN_BIT] = xfer_enable_per_source;
    end else if (reg_addr == `XNM_OFS_VECACT) begin
      reg_rdata[`XNM_VECACT_SAE_BIT] = soft_activation_enable;
      reg_rdata[`XNM_VECACT_VEC_HI:0] = vec_num;
    end else if (reg_addr == `XNM_OFS_VBASE) begin
      reg_rdata = vbase;
    end else if (reg_addr == `XNM_OFS_STAT) begin
      reg_rdata[`XNM_STAT_PEND_BIT] = pending_request_flag;
      reg_rdata[`XNM_STAT_BUSY_BIT] = (state != XNM_IDLE);
      reg_rdata[`XNM_STAT_IRQ_BIT] = cpu_irq;
      reg_rdata[`XNM_STAT_CNT_LO +: 16] = count_a;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      vbase <= `XNM_VBASE_RST;
      vec_num <= 7'h00;
    end else begin
      if (reg_wr && reg_addr == `XNM_OFS_VBASE) begin
        vbase <= reg_wdata;
      end
      if (wr_vecact) begin
        vec_num <= reg_wdata[`XNM_VECACT_VEC_HI:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer events
  // ----------------------------------------------------------------
  assign activate = (state == XNM_IDLE) &&
                    (FLAG_VARIANT ? (pending_request_flag && xfer_enable_per_source) // RQ2
                                  : act_req); // RQ1
  assign xfer_start = (state == XNM_INFO_RD) && mem_ack && (idx == `XNM_INFO_LAST_IDX);
  assign start_final = (mem_rdata[15:0] == `XNM_CNT_ONE); // RQ6
  assign xfer_done = (state == XNM_FIN);
  assign done_final = (count_a == `XNM_CNT_ZERO);
  assign mem_req = (state != XNM_IDLE) && (state != XNM_FIN);
  assign next_src = adv(src, src_mode, xsize);
  assign next_dst = adv(dst, dst_mode, xsize);

  // ----------------------------------------------------------------
  // Main state machine and memory port
  // ----------------------------------------------------------------
  // Memory fields are loaded on the edge that enters each access state,
  // so the port never shows a half-updated request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= XNM_IDLE;
      idx <= 2'h0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_size <= `XNM_SZ_WORD;
      mem_wdata <= 32'h0000_0000;
      info_base <= 32'h0000_0000;
      src <= 32'h0000_0000;
      dst <= 32'h0000_0000;
      count_a <= `XNM_CNT_ZERO;
      src_mode <= `XNM_AM_FIXED;
      dst_mode <= `XNM_AM_FIXED;
      xsize <= `XNM_SZ_BYTE;
      every <= 1'b0;
    end else begin
      case (state)
        XNM_IDLE: begin
          if (activate) begin
            state <= XNM_VEC_RD;
            mem_we <= 1'b0;
            mem_size <= `XNM_SZ_WORD;
            mem_addr <= vbase + {23'h0, FLAG_VARIANT ? SRC_VECTOR : vec_num, 2'h0}; // RQ4
          end
        end
        XNM_VEC_RD: begin
          if (mem_ack) begin
            info_base <= mem_rdata;
            mem_addr <= mem_rdata; // RQ5
            idx <= 2'h0;
            state <= XNM_INFO_RD;
          end
        end
        XNM_INFO_RD: begin
          if (mem_ack) begin
            case (idx)
              2'h0: begin
                src_mode <= mem_rdata[`XNM_MODE_SRC_LO +: 2];
                dst_mode <= mem_rdata[`XNM_MODE_DST_LO +: 2];
                xsize <= eff_size(mem_rdata[`XNM_MODE_SIZE_LO +: 2]);
                every <= mem_rdata[`XNM_MODE_EVERY_BIT]; // RQ22
              end
              2'h1: src <= mem_rdata;
              2'h2: dst <= mem_rdata;
              default: count_a <= mem_rdata[15:0]; // RQ21
            endcase
            if (idx == `XNM_INFO_LAST_IDX) begin
              state <= XNM_DAT_RD; // RQ5
              mem_addr <= src;
              mem_size <= xsize;
            end else begin
              idx <= idx + 2'h1;
              mem_addr <= mem_addr + `XNM_WORD_STEP;
            end
          end
        end
        XNM_DAT_RD: begin
          if (mem_ack) begin
            mem_we <= 1'b1;
            mem_addr <= dst;
            mem_wdata <= mem_rdata;
            state <= XNM_DAT_WR;
          end
        end
        XNM_DAT_WR: begin
          if (mem_ack) begin
            count_a <= count_a - `XNM_CNT_DEC; // RQ7
            src <= next_src; // RQ20
            dst <= next_dst;
            idx <= `XNM_INFO_FIRST_WB;
            mem_size <= `XNM_SZ_WORD;
            mem_addr <= info_base + `XNM_WORD_STEP;
            mem_wdata <= next_src;
            state <= XNM_WB; // RQ8 RQ15
          end
        end
        XNM_WB: begin
          if (mem_ack) begin
            if (idx == `XNM_INFO_LAST_IDX) begin
              mem_we <= 1'b0;
              state <= XNM_FIN;
            end else begin
              idx <= idx + 2'h1;
              mem_addr <= mem_addr + `XNM_WORD_STEP;
              mem_wdata <= (idx == `XNM_INFO_FIRST_WB) ? dst : {16'h0000, count_a};
            end
          end
        end
        default: begin
          state <= XNM_IDLE; // Completion check happens in this one cycle
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flag-variant request state
  // ----------------------------------------------------------------
  // A software set in the same cycle as a hardware clear wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pending_request_flag <= 1'b0;
    end else if (FLAG_VARIANT && wr_swreq && reg_wdata[`XNM_SWREQ_BIT]) begin
      pending_request_flag <= 1'b1; // RQ3 RQ10
    end else if (FLAG_VARIANT && xfer_start && !start_final) begin
      pending_request_flag <= 1'b0; // RQ6 RQ11
    end else if (wr_iack) begin
      pending_request_flag <= 1'b0; // RQ13
    end
  end

  // Source enable: software write wins over the final-count clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      xfer_enable_per_source <= 1'b0;
    end else if (wr_ctrl) begin
      xfer_enable_per_source <= reg_wdata[`XNM_CTRL_XEN_BIT]; // RQ2
    end else if (FLAG_VARIANT && xfer_done && done_final) begin
      xfer_enable_per_source <= 1'b0; // RQ12 RQ9
    end
  end

  // ----------------------------------------------------------------
  // Enable-variant request state
  // ----------------------------------------------------------------
  // Enable bit alone would retrigger after the final pass, so a write of 1
  // also arms a one-shot request consumed at activation
  always_ff @(posedge core_clk) begin
    if (srst) begin
      soft_activation_enable <= 1'b0;
    end else if (wr_vecact) begin
      soft_activation_enable <= reg_wdata[`XNM_VECACT_SAE_BIT]; // RQ17 RQ19
    end else if (!FLAG_VARIANT && xfer_done && !done_final) begin
      soft_activation_enable <= 1'b0; // RQ16 RQ18
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      act_req <= 1'b0;
    end else if (!FLAG_VARIANT && wr_vecact && reg_wdata[`XNM_VECACT_SAE_BIT]) begin
      act_req <= 1'b1; // RQ14
    end else if (activate) begin
      act_req <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // CPU interrupt request
  // ----------------------------------------------------------------
  // Raised on the final count, or after every datum when the mode word asks;
  // acknowledge (or clearing the enable bit in the enable variant) drops it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpu_irq <= 1'b0;
    end else if (xfer_done && (done_final || every)) begin
      cpu_irq <= 1'b1; // RQ12 RQ18 RQ22 RQ9
    end else if (wr_iack) begin
      cpu_irq <= 1'b0;
    end else if (!FLAG_VARIANT && wr_vecact && !reg_wdata[`XNM_VECACT_SAE_BIT]) begin
      cpu_irq <= 1'b0; // RQ19
    end
  end
endmodule
